// file: design/fcs_host.sv
// host-side command sequencer driving an asynchronous banked nor flash
module fcs_host
    import fcs_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // command port
    input wire logic i_cmd_valid,
    input wire fcs_pkg::fcs_cmd_type i_cmd_code,
    input wire logic [fcs_pkg::ADDR_W-1:0] i_cmd_addr,
    input wire logic [fcs_pkg::DATA_W-1:0] i_cmd_data,
    output logic o_cmd_ready,
    // read answers
    output logic o_rd_valid,
    output logic [fcs_pkg::DATA_W-1:0] o_rd_data,
    output logic o_timing_limit_flag,
    // flash pins
    output logic [fcs_pkg::ADDR_W-1:0] o_flash_addr,
    output logic o_flash_ce_b,
    output logic o_flash_we_b,
    output logic o_flash_oe_b,
    output logic [fcs_pkg::DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [fcs_pkg::DATA_W-1:0] i_dq_in
);
    import fcs_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ARM, ST_PULSE, ST_RECOVER} fcs_state_type;

    fcs_state_type state_ff, nxt_state;
    fcs_cmd_type cmd_ff, nxt_cmd;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] data_ff, nxt_data;
    logic [STEP_W-1:0] step_ff, nxt_step;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic ready_ff, nxt_ready;
    logic rd_valid_ff, nxt_rd_valid;
    logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
    logic limit_ff, nxt_limit;
    logic [ADDR_W-1:0] pin_addr_ff, nxt_pin_addr;
    logic ce_b_ff, nxt_ce_b;
    logic we_b_ff, nxt_we_b;
    logic oe_b_ff, nxt_oe_b;
    logic [DATA_W-1:0] dq_out_ff, nxt_dq_out;
    logic dq_oe_ff, nxt_dq_oe;
    logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;

    logic [ADDR_W-1:0] st_addr;
    logic [DATA_W-1:0] st_data;
    logic st_read;
    logic st_last;
    logic unlock_cmd;
    logic [BANK_W-1:0] bank;

    // bank-relative address with everything between bank and low field zero
    function automatic logic [ADDR_W-1:0] bank_adr(input logic [BANK_W-1:0] b, input logic [11:0] low);
        bank_adr = {b, (BANK_LSB - 12)'(0), low};
    endfunction

    // step decode: address, data and kind of each bus cycle
    always_comb begin
        bank = addr_ff[ADDR_W-1:BANK_LSB];
        unlock_cmd = !(cmd_ff inside {FCS_READ, FCS_RESET, FCS_SECTOR_ADD, FCS_SUSPEND, FCS_RESUME, FCS_CFI,
                                      FCS_BYPASS_PROGRAM, FCS_BYPASS_ERASE, FCS_BYPASS_RESET});
        st_addr = bank_adr(bank, ADR_ZERO);
        st_data = D_ZERO;
        st_read = 1'b0;
        st_last = 1'b0;
        if (unlock_cmd && step_ff == 3'h0) begin
            st_addr = bank_adr(bank, ADR_UNLOCK1);
            st_data = D_UNLOCK1;
        end else if (unlock_cmd && step_ff == 3'h1) begin
            st_addr = bank_adr(bank, ADR_UNLOCK2);
            st_data = D_UNLOCK2;
        end else begin
            unique case (cmd_ff)
                FCS_READ: begin
                    st_addr = addr_ff;
                    st_read = 1'b1;
                    st_last = 1'b1;
                end
                FCS_RESET: begin
                    st_data = D_RESET;
                    st_last = 1'b1;
                end
                FCS_ID_MAKER, FCS_SECURED_QUERY, FCS_GROUP_VERIFY, FCS_ID_DEVICE: begin
                    if (step_ff == 3'h2) begin
                        st_addr = bank_adr(bank, ADR_UNLOCK1);
                        st_data = D_IDENT;
                    end else begin
                        st_read = 1'b1;
                        unique case (cmd_ff)
                            FCS_ID_MAKER: begin
                                st_addr = bank_adr(bank, ADR_MAKER_ID);
                                st_last = 1'b1;
                            end
                            FCS_SECURED_QUERY: begin
                                st_addr = bank_adr(bank, ADR_SECURED_QUERY);
                                st_last = 1'b1;
                            end
                            FCS_GROUP_VERIFY: begin
                                st_addr = {addr_ff[ADDR_W-1:SECT_LSB], ADR_GROUP_VERIFY};
                                st_last = 1'b1;
                            end
                            default: begin
                                // device id spans three reads
                                st_addr = bank_adr(bank, step_ff == 3'h3 ? ADR_DEV_ID1 :
                                                   step_ff == 3'h4 ? ADR_DEV_ID2 : ADR_DEV_ID3);
                                st_last = (step_ff == 3'h5);
                            end
                        endcase
                    end
                end
                FCS_PROGRAM: begin
                    if (step_ff == 3'h2) begin
                        st_addr = bank_adr(bank, ADR_UNLOCK1);
                        st_data = D_PROGRAM;
                    end else begin
                        st_addr = addr_ff;
                        st_data = data_ff;
                        st_last = 1'b1;
                    end
                end
                FCS_CHIP_ERASE, FCS_SECTOR_ERASE: begin
                    unique case (step_ff)
                        3'h2: begin
                            st_addr = bank_adr(bank, ADR_UNLOCK1);
                            st_data = D_ERASE_SETUP;
                        end
                        3'h3: begin
                            st_addr = bank_adr(bank, ADR_UNLOCK1);
                            st_data = D_UNLOCK1;
                        end
                        3'h4: begin
                            st_addr = bank_adr(bank, ADR_UNLOCK2);
                            st_data = D_UNLOCK2;
                        end
                        default: begin
                            st_last = 1'b1;
                            if (cmd_ff == FCS_CHIP_ERASE) begin
                                st_addr = bank_adr(bank, ADR_UNLOCK1);
                                st_data = D_CHIP_ERASE;
                            end else begin
                                st_addr = {addr_ff[ADDR_W-1:SECT_LSB], ADR_ZERO};
                                st_data = D_SECTOR_ERASE;
                            end
                        end
                    endcase
                end
                FCS_SECTOR_ADD: begin
                    st_addr = {addr_ff[ADDR_W-1:SECT_LSB], ADR_ZERO};
                    st_data = D_SECTOR_ERASE;
                    st_last = 1'b1;
                end
                FCS_SUSPEND: begin
                    st_data = D_SUSPEND;
                    st_last = 1'b1;
                end
                FCS_RESUME: begin
                    st_data = D_RESUME;
                    st_last = 1'b1;
                end
                FCS_CFI: begin
                    st_addr = bank_adr(bank, ADR_CFI);
                    st_data = D_CFI;
                    st_last = 1'b1;
                end
                FCS_BYPASS_ENTRY, FCS_SECURED_ENTRY, FCS_SECURED_EXIT: begin
                    st_addr = bank_adr(bank, ADR_UNLOCK1);
                    st_data = cmd_ff == FCS_BYPASS_ENTRY ? D_BYPASS_ENTRY :
                              cmd_ff == FCS_SECURED_ENTRY ? D_SECURED_ENTRY : D_IDENT;
                    st_last = (cmd_ff != FCS_SECURED_EXIT);
                    if (step_ff == 3'h3) begin
                        st_addr = bank_adr(bank, ADR_ZERO);
                        st_data = D_ZERO;
                        st_last = 1'b1;
                    end
                end
                FCS_BYPASS_PROGRAM: begin
                    st_data = step_ff == 3'h0 ? D_PROGRAM : data_ff;
                    st_addr = step_ff == 3'h0 ? bank_adr(bank, ADR_ZERO) : addr_ff;
                    st_last = (step_ff == 3'h1);
                end
                FCS_BYPASS_ERASE: begin
                    st_data = step_ff == 3'h0 ? D_ERASE_SETUP : D_CHIP_ERASE;
                    st_last = (step_ff == 3'h1);
                end
                FCS_BYPASS_RESET: begin
                    st_data = step_ff == 3'h0 ? D_IDENT : D_ZERO;
                    st_last = (step_ff == 3'h1);
                end
            endcase
        end
    end

    // bus cycle sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_cmd = cmd_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        nxt_step = step_ff;
        nxt_cnt = cnt_ff;
        nxt_ready = ready_ff;
        nxt_rd_valid = 1'b0;
        nxt_rd_data = rd_data_ff;
        nxt_limit = limit_ff;
        nxt_pin_addr = pin_addr_ff;
        nxt_ce_b = ce_b_ff;
        nxt_we_b = we_b_ff;
        nxt_oe_b = oe_b_ff;
        nxt_dq_out = dq_out_ff;
        nxt_dq_oe = dq_oe_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (i_cmd_valid && ready_ff) begin
                    nxt_cmd = i_cmd_code;
                    nxt_addr = i_cmd_addr;
                    nxt_data = i_cmd_data;
                    nxt_step = '0;
                    nxt_ready = 1'b0;
                    nxt_state = ST_SETUP;
                    if (i_cmd_code == FCS_RESET) begin
                        nxt_limit = 1'b0;
                    end
                end
            end
            ST_SETUP: begin
                // address and data settle with chip enable, before the strobe
                nxt_pin_addr = st_addr;
                nxt_dq_out = st_data;
                nxt_dq_oe = !st_read;
                nxt_ce_b = 1'b0;
                nxt_state = ST_ARM;
            end
            ST_ARM: begin
                if (st_read) begin
                    nxt_oe_b = 1'b0;
                    nxt_cnt = CNT_W'(READ_CYC - 1);
                end else begin
                    nxt_we_b = 1'b0;
                    nxt_cnt = CNT_W'(WE_LOW_CYC - 1);
                end
                nxt_state = ST_PULSE;
            end
            ST_PULSE: begin
                nxt_cnt = cnt_ff - CNT_W'(1);
                if (cnt_ff == '0) begin
                    // write enable rises while chip enable and data still hold
                    nxt_we_b = 1'b1;
                    nxt_oe_b = 1'b1;
                    nxt_cnt = CNT_W'(WE_HIGH_CYC - 1);
                    nxt_state = ST_RECOVER;
                    if (st_read) begin
                        nxt_rd_data = dq_s2_ff;
                        nxt_rd_valid = 1'b1;
                        nxt_limit = dq_s2_ff[STATUS_LIMIT_BIT];
                    end
                end
            end
            ST_RECOVER: begin
                nxt_ce_b = 1'b1;
                nxt_dq_oe = 1'b0;
                nxt_cnt = cnt_ff - CNT_W'(1);
                if (cnt_ff == '0) begin
                    if (st_last) begin
                        nxt_ready = 1'b1;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_step = step_ff + STEP_W'(1);
                        nxt_state = ST_SETUP;
                    end
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= ST_IDLE;
            cmd_ff <= FCS_READ;
            addr_ff <= '0;
            data_ff <= '0;
            step_ff <= '0;
            cnt_ff <= '0;
            ready_ff <= 1'b1;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= '0;
            limit_ff <= 1'b0;
            pin_addr_ff <= '0;
            ce_b_ff <= 1'b1;
            we_b_ff <= 1'b1;
            oe_b_ff <= 1'b1;
            dq_out_ff <= '0;
            dq_oe_ff <= 1'b0;
            dq_s1_ff <= '0;
            dq_s2_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cmd_ff <= nxt_cmd;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            step_ff <= nxt_step;
            cnt_ff <= nxt_cnt;
            ready_ff <= nxt_ready;
            rd_valid_ff <= nxt_rd_valid;
            rd_data_ff <= nxt_rd_data;
            limit_ff <= nxt_limit;
            pin_addr_ff <= nxt_pin_addr;
            ce_b_ff <= nxt_ce_b;
            we_b_ff <= nxt_we_b;
            oe_b_ff <= nxt_oe_b;
            dq_out_ff <= nxt_dq_out;
            dq_oe_ff <= nxt_dq_oe;
            dq_s1_ff <= i_dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    // outputs straight from flops
    assign o_cmd_ready = ready_ff;
    assign o_rd_valid = rd_valid_ff;
    assign o_rd_data = rd_data_ff;
    assign o_timing_limit_flag = limit_ff;
    assign o_flash_addr = pin_addr_ff;
    assign o_flash_ce_b = ce_b_ff;
    assign o_flash_we_b = we_b_ff;
    assign o_flash_oe_b = oe_b_ff;
    assign o_dq_out = dq_out_ff;
    assign o_dq_oe = dq_oe_ff;
endmodule

// file: design/fcs_pkg.sv
// constants and types for the flash command sequencer (host end)
package fcs_pkg;
    // bus widths and field positions
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int BANK_W = 3;
    localparam int BANK_LSB = 20;
    localparam int SECT_LSB = 12;
    localparam int STEP_W = 3;
    localparam int CNT_W = 8;
    localparam int STATUS_LIMIT_BIT = 5;
    // unlock and command addresses (low bits only)
    localparam logic [11:0] ADR_UNLOCK1 = 12'h555;
    localparam logic [11:0] ADR_UNLOCK2 = 12'h2AA;
    localparam logic [11:0] ADR_CFI = 12'h055;
    localparam logic [11:0] ADR_MAKER_ID = 12'h000;
    localparam logic [11:0] ADR_DEV_ID1 = 12'h001;
    localparam logic [11:0] ADR_DEV_ID2 = 12'h00E;
    localparam logic [11:0] ADR_DEV_ID3 = 12'h00F;
    localparam logic [11:0] ADR_GROUP_VERIFY = 12'h002;
    localparam logic [11:0] ADR_SECURED_QUERY = 12'h003;
    localparam logic [11:0] ADR_ZERO = 12'h000;
    // command data codes
    localparam logic [15:0] D_UNLOCK1 = 16'h00AA;
    localparam logic [15:0] D_UNLOCK2 = 16'h0055;
    localparam logic [15:0] D_RESET = 16'h00F0;
    localparam logic [15:0] D_IDENT = 16'h0090;
    localparam logic [15:0] D_PROGRAM = 16'h00A0;
    localparam logic [15:0] D_ERASE_SETUP = 16'h0080;
    localparam logic [15:0] D_CHIP_ERASE = 16'h0010;
    localparam logic [15:0] D_SECTOR_ERASE = 16'h0030;
    localparam logic [15:0] D_SUSPEND = 16'h00B0;
    localparam logic [15:0] D_RESUME = 16'h0030;
    localparam logic [15:0] D_CFI = 16'h0098;
    localparam logic [15:0] D_BYPASS_ENTRY = 16'h0020;
    localparam logic [15:0] D_SECURED_ENTRY = 16'h0088;
    localparam logic [15:0] D_ZERO = 16'h0000;
    // bus timing
    localparam int CLK_NS = 10;
    localparam int WE_LOW_NS = 35;
    localparam int WE_HIGH_NS = 25;
    localparam int READ_ACCESS_NS = 65;
    localparam int SYNC_STAGES = 2;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    // host commands
    typedef enum logic [4:0] {
        FCS_READ, FCS_RESET, FCS_ID_MAKER, FCS_ID_DEVICE, FCS_SECURED_QUERY,
        FCS_GROUP_VERIFY, FCS_PROGRAM, FCS_CHIP_ERASE, FCS_SECTOR_ERASE,
        FCS_SECTOR_ADD, FCS_SUSPEND, FCS_RESUME, FCS_CFI, FCS_BYPASS_ENTRY,
        FCS_BYPASS_PROGRAM, FCS_BYPASS_ERASE, FCS_BYPASS_RESET,
        FCS_SECURED_ENTRY, FCS_SECURED_EXIT
    } fcs_cmd_type;
endpackage

// file: tb/fcs_flash_model.sv
// behavioural banked nor flash that answers the host sequencer
module fcs_flash_model #(
    parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
    parameter logic [15:0] DEV_ID1 = 16'h1357, // arbitrary value
    parameter logic [15:0] DEV_ID2 = 16'h2468, // arbitrary value
    parameter logic [15:0] DEV_ID3 = 16'h3579, // arbitrary value
    parameter logic [15:0] LOCK_CODE = 16'h0084
) (
    // flash pins from the host
    input wire logic [22:0] i_addr,
    input wire logic i_ce_b,
    input wire logic i_we_b,
    input wire logic i_oe_b,
    input wire logic [15:0] i_dq,
    input wire logic i_dq_oe,
    // level the flash puts on dq
    output logic [15:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [256];
    logic [2:0] st [8];
    logic asel [8], byp [8], prog [8], ers [8];
    logic [22:0] lat_a, last_a;
    logic [15:0] last_d;
    logic open_cyc;
    int n_erase;
    // per-bank sequence state starts in array read
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        foreach (st[i]) begin st[i] = 3'd0; asel[i] = 0; byp[i] = 0; prog[i] = 0; ers[i] = 0; end
        open_cyc = 0;
        n_erase = 0;
        o_dq = 16'h0000;
    end
    // one write cycle: only low address and data bits steer the sequence
    task automatic wr(input logic [22:0] a, input logic [15:0] d);
        logic [2:0] b;
        b = a[22:20];
        last_a = a;
        last_d = d;
        if (prog[b]) begin mem[a[7:0]] = d; prog[b] = 0; end
        // erasing bank swallows writes; only more sectors, suspend or resume (same code as a sector) keep it erasing
        else if (ers[b]) ers[b] = (d[7:0] == 8'h30 || d[7:0] == 8'hB0);
        else if (d[7:0] == 8'hF0) begin st[b] = 3'd0; asel[b] = 0; end
        else if (byp[b] && st[b] == 3'd7) begin byp[b] = (d[7:0] != 8'h00); st[b] = 3'd0; end
        else if (byp[b] && d[7:0] == 8'hA0) prog[b] = 1;
        else if (byp[b] && d[7:0] == 8'h90) st[b] = 3'd7;
        else case (st[b])
            3'd0, 3'd3: st[b] = (a[11:0] == 12'h555 && d[7:0] == 8'hAA) ? st[b] + 3'd1 : 3'd0;
            3'd1, 3'd4: st[b] = (a[11:0] == 12'h2AA && d[7:0] == 8'h55) ? st[b] + 3'd1 : 3'd0;
            3'd2: begin
                st[b] = (d[7:0] == 8'h80) ? 3'd3 : 3'd0;
                asel[b] = asel[b] | (d[7:0] == 8'h90);
                prog[b] = (d[7:0] == 8'hA0);
                byp[b] = byp[b] | (d[7:0] == 8'h20);
            end
            default: begin
                if (d[7:0] == 8'h10 || d[7:0] == 8'h30) n_erase++;
                ers[b] = (d[7:0] == 8'h30);
                st[b] = 3'd0;
            end
        endcase
    endtask
    // read word: array data, or identification codes in autoselect
    function automatic logic [15:0] rd(input logic [22:0] a);
        if (!asel[a[22:20]]) return mem[a[7:0]];
        case (a[11:0])
            12'h000: return MAKER_ID;
            12'h001: return DEV_ID1;
            12'h00E: return DEV_ID2;
            12'h00F: return DEV_ID3;
            12'h002: return {15'h0000, a[12]};
            12'h003: return LOCK_CODE;
            default: return mem[a[7:0]];
        endcase
    endfunction
    // address on the later falling strobe
    always @(negedge i_we_b or negedge i_ce_b) if (!i_we_b && !i_ce_b) begin lat_a = i_addr; open_cyc = 1; end
    // data on the earlier rising strobe, undriven dq seen inverted
    always @(posedge i_we_b or posedge i_ce_b) if (open_cyc) begin open_cyc = 0; wr(lat_a, i_dq_oe ? i_dq : ~i_dq); end
    // drive when selected and enabled, else a changing pattern
    always @(i_ce_b or i_oe_b or i_addr) o_dq = (!i_ce_b && !i_oe_b) ? rd(i_addr) : ~o_dq;
endmodule

// file: tb/fcs_host_properties.sv
// concurrent checks on the host sequencer ports
module fcs_host_properties
    import fcs_pkg::*;
(
    input wire logic i_clock, i_rst_b, i_cmd_valid,
    input wire fcs_pkg::fcs_cmd_type i_cmd_code,
    input wire logic [fcs_pkg::ADDR_W-1:0] i_cmd_addr, o_flash_addr,
    input wire logic [fcs_pkg::DATA_W-1:0] i_cmd_data, o_rd_data, o_dq_out, i_dq_in,
    input wire logic o_cmd_ready, o_rd_valid, o_timing_limit_flag,
    input wire logic o_flash_ce_b, o_flash_we_b, o_flash_oe_b, o_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    // write strobe low four cycles then released
    sequence we_pulse_s; !o_flash_we_b [*4] ##1 o_flash_we_b; endsequence
    // output enable low nine cycles then released
    sequence oe_window_s; ##8 !o_flash_oe_b ##1 o_flash_oe_b; endsequence
    sequence took_s(fcs_cmd_type c); o_cmd_ready && i_cmd_valid && i_cmd_code == c; endsequence
    unlock_bits_a: assert property ($fell(o_flash_we_b) && o_flash_addr[11:0] == 12'h2AA && o_dq_out == 16'h0055
        |-> o_flash_addr[19:12] == 8'h00) else $error("unlock cycle drives upper address bits");
    addr_hold_a: assert property (!o_flash_we_b && !$past(o_flash_we_b) |-> $stable(o_flash_addr))
        else $error("address moved during write pulse");
    strobe_nest_a: assert property (!o_flash_we_b |-> !o_flash_ce_b && o_dq_oe && o_flash_oe_b)
        else $error("write pulse outside chip select");
    data_hold_a: assert property ($rose(o_flash_we_b) |-> !o_flash_ce_b && o_dq_oe && $stable(o_dq_out))
        else $error("data released with write strobe");
    we_width_a: assert property ($fell(o_flash_we_b) |-> we_pulse_s) else $error("write pulse width wrong");
    oe_width_a: assert property ($fell(o_flash_oe_b) |-> oe_window_s) else $error("read pulse width wrong");
    read_answer_a: assert property (took_s(FCS_READ) |-> ##[1:20] o_rd_valid)
        else $error("plain read gave no answer");
    flag_clear_a: assert property (took_s(FCS_RESET) |=> !o_timing_limit_flag)
        else $error("limit flag not cleared by reset command");
    flag_bit_a: assert property (o_rd_valid |-> o_timing_limit_flag == o_rd_data[STATUS_LIMIT_BIT])
        else $error("limit flag differs from read word");
endmodule
bind fcs_host fcs_host_properties fcs_host_properties_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data),
    .o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_timing_limit_flag(o_timing_limit_flag), .o_flash_addr(o_flash_addr), .o_flash_ce_b(o_flash_ce_b),
    .o_flash_we_b(o_flash_we_b), .o_flash_oe_b(o_flash_oe_b), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
    .i_dq_in(i_dq_in));

// file: tb/fcs_host_tb_top.sv
// self-checking bench for the host flash sequencer
module fcs_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fcs_pkg::*;
    // identification values are arbitrary, shared with the flash model
    localparam logic [15:0] MAKER = 16'h00A5, DEV1 = 16'h1357, DEV2 = 16'h2468, DEV3 = 16'h3579, LOCK = 16'h0084;
    logic i_clock, i_rst_b, i_cmd_valid, o_cmd_ready, o_rd_valid, o_timing_limit_flag;
    logic o_flash_ce_b, o_flash_we_b, o_flash_oe_b, o_dq_oe;
    fcs_cmd_type i_cmd_code;
    logic [ADDR_W-1:0] i_cmd_addr, o_flash_addr;
    logic [DATA_W-1:0] i_cmd_data, o_rd_data, o_dq_out, i_dq_in, flash_q;
    logic [DATA_W-1:0] rdq [$];
    int n_mismatch = 0, compares = 0;
    fcs_host fcs_host_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code),
        .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_timing_limit_flag(o_timing_limit_flag), .o_flash_addr(o_flash_addr),
        .o_flash_ce_b(o_flash_ce_b), .o_flash_we_b(o_flash_we_b), .o_flash_oe_b(o_flash_oe_b),
        .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in));
    fcs_flash_model #(.MAKER_ID(MAKER), .DEV_ID1(DEV1), .DEV_ID2(DEV2), .DEV_ID3(DEV3), .LOCK_CODE(LOCK))
        fcs_flash_model_i (.i_addr(o_flash_addr), .i_ce_b(o_flash_ce_b), .i_we_b(o_flash_we_b),
        .i_oe_b(o_flash_oe_b), .i_dq(o_dq_out), .i_dq_oe(o_dq_oe), .o_dq(flash_q));
    // wire level: host drives while enabled, else the flash
    assign i_dq_in = o_dq_oe ? o_dq_out : flash_q;
    // clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // collect every read answer
    always @(posedge i_clock) if (o_rd_valid === 1'b1) rdq.push_back(o_rd_data);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // issue one command and wait until the sequencer is idle again
    task automatic cmd(input fcs_cmd_type c, input logic [22:0] a, input logic [15:0] d);
        int n;
        n = 0;
        rdq.delete();
        @(posedge i_clock);
        i_cmd_valid <= 1'b1;
        i_cmd_code <= c;
        i_cmd_addr <= a;
        i_cmd_data <= d;
        @(posedge i_clock);
        i_cmd_valid <= 1'b0;
        repeat (2) @(posedge i_clock);
        while (o_cmd_ready !== 1'b1 && n < 300) begin @(posedge i_clock); n++; end
        if (n >= 300) chk(0, 1);
    endtask
    task automatic t_program_read;
        cmd(FCS_PROGRAM, 23'h100010, 16'hBEEF);
        chk(fcs_flash_model_i.last_a, 23'h100010);
        cmd(FCS_READ, 23'h100010, 16'h0000);
        chk(rdq.size(), 1);
        chk(rdq[0], 16'hBEEF);
        cmd(FCS_PROGRAM, 23'h100020, 16'h0020);
        cmd(FCS_READ, 23'h100020, 16'h0000);
        chk(o_timing_limit_flag, 1);
        cmd(FCS_RESET, 23'h100000, 16'h0000);
        chk(o_timing_limit_flag, 0);
    endtask
    task automatic t_ident;
        cmd(FCS_ID_MAKER, 23'h200000, 16'h0000);
        chk(rdq[0], MAKER);
        cmd(FCS_ID_DEVICE, 23'h200000, 16'h0000);
        chk(rdq.size(), 3);
        chk(rdq[0], DEV1);
        chk(rdq[1], DEV2);
        chk(rdq[2], DEV3);
        cmd(FCS_READ, 23'h100010, 16'h0000);
        chk(rdq[0], 16'hBEEF);
        cmd(FCS_SECURED_QUERY, 23'h200000, 16'h0000);
        chk(rdq[0], LOCK);
        cmd(FCS_GROUP_VERIFY, 23'h201000, 16'h0000);
        chk(rdq[0], 16'h0001);
        cmd(FCS_GROUP_VERIFY, 23'h202000, 16'h0000);
        chk(rdq[0], 16'h0000);
        cmd(FCS_RESET, 23'h200000, 16'h0000);
        cmd(FCS_READ, 23'h200010, 16'h0000);
        chk(rdq[0], 16'hBEEF);
    endtask
    task automatic t_bypass;
        cmd(FCS_BYPASS_ENTRY, 23'h100000, 16'h0000);
        chk(fcs_flash_model_i.byp[1], 1);
        cmd(FCS_BYPASS_PROGRAM, 23'h100030, 16'hC3A5);
        cmd(FCS_BYPASS_RESET, 23'h100000, 16'h0000);
        chk(fcs_flash_model_i.byp[1], 0);
        cmd(FCS_READ, 23'h100030, 16'h0000);
        chk(rdq[0], 16'hC3A5);
    endtask
    // remaining write-only commands: last cycle code and bank or sector
    task automatic t_table;
        fcs_cmd_type tc [9] = '{FCS_SECTOR_ERASE, FCS_SECTOR_ADD, FCS_SUSPEND, FCS_RESUME, FCS_CHIP_ERASE,
            FCS_CFI, FCS_SECURED_ENTRY, FCS_SECURED_EXIT, FCS_BYPASS_ERASE};
        logic [22:0] ta [9] = '{23'h345000, 23'h346000, 23'h300000, 23'h300000, 23'h400000, 23'h500000,
            23'h600000, 23'h600000, 23'h700000};
        logic [7:0] td [9] = '{8'h30, 8'h30, 8'hB0, 8'h30, 8'h10, 8'h98, 8'h88, 8'h00, 8'h10};
        for (int i = 0; i < 9; i++) begin
            cmd(tc[i], ta[i], 16'h0000);
            chk(fcs_flash_model_i.last_d, {8'h00, td[i]});
            chk(fcs_flash_model_i.last_a[22:12], ta[i][22:12]);
        end
        chk(fcs_flash_model_i.n_erase, 2);
        // bank 3 window survives add, suspend, resume; a CFI command ends it
        chk(fcs_flash_model_i.ers[3], 1);
        cmd(FCS_CFI, 23'h300000, 16'h0000);
        chk(fcs_flash_model_i.ers[3], 0);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run of under a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        i_rst_b = 1'b0;
        i_cmd_valid = 1'b0;
        i_cmd_code = FCS_READ;
        i_cmd_addr = '0;
        i_cmd_data = '0;
        repeat (3) @(posedge i_clock);
        chk({o_cmd_ready, o_rd_valid, o_flash_ce_b, o_flash_we_b, o_flash_oe_b, o_dq_oe}, 6'h2E);
        i_rst_b <= 1'b1;
        t_program_read();
        t_ident();
        t_bypass();
        t_table();
        tally_and_finish();
    end
endmodule
